// [rtl/its_pkg.sv]
/*
 * Shared constants and types of the two-wire slave with bus time-out.
 * Assumes one 200 MHz system clock and an 8-bit register port.
 */
package its_pkg;

    // ************************************************************
    // Register map and widths.
    // ************************************************************
    localparam int DW = 8;                   // Register data width.
    localparam int AW = 3;                   // Register address width.
    localparam logic [AW-1:0] OFS_DATA = 3'h0;  // Shared data register.
    localparam logic [AW-1:0] OFS_ADDR = 3'h1;  // Own address register.
    localparam logic [AW-1:0] OFS_CTLA = 3'h2;  // First control register.
    localparam logic [AW-1:0] OFS_CTLB = 3'h3;  // Control and status.
    localparam logic [AW-1:0] OFS_TOC = 3'h4;   // Bus time-out control.

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CTLA_EN = 0;              // Slave enable.
    localparam int CTLB_ACK_RECEIVED_STATUS = 0;            // Acknowledge received, low.
    localparam int CTLB_MRF = 2;             // Master read flag.
    localparam int CTLB_ACK = 3;             // Acknowledge to send.
    localparam int CTLB_TDS = 4;             // Transmit direction select.
    localparam int CTLB_AMF = 6;             // Address matched flag.
    localparam int TOC_EN = 7;               // Time-out enable.
    localparam int TOC_FLAG = 6;             // Time-out flag.
    localparam int TOC_PER_HI = 5;           // Period field top bit.
    localparam int TOC_PER_W = 6;            // Period field width.

    // ************************************************************
    // Reset values.
    // ************************************************************
    localparam logic [DW-1:0] DATA_RST = 8'h00;  // Data register.
    localparam logic [DW-1:0] ADDR_RST = 8'h00;  // Own address.
    localparam logic [DW-1:0] CTLA_RST = 8'h00;  // Control A.
    localparam logic [DW-1:0] TOC_RST = 8'h00;   // Time-out control.
    localparam logic ACK_RECEIVED_STATUS_RST = 1'b1;        // No acknowledge seen yet.

    // ************************************************************
    // Timing counts.
    // ************************************************************
    localparam int SUB_DIV = 32;             // Sub-clock cycles per tick.
    localparam int DIV_W = 5;                // Width of the divider.
    localparam int BIT_W = 4;                // Width of the bit counter.
    localparam logic [BIT_W-1:0] BITS_BYTE = 4'h8;  // Bits in a byte.
    localparam logic [BIT_W-1:0] BITS_ADR = 4'h7;   // Last address index.

    // Events on the synchronised pins.
    typedef struct packed {
        logic start;                         // SDA falls while SCL high.
        logic stop;                          // SDA rises while SCL high.
        logic scl_rise;                      // SCL rising edge.
        logic scl_fall;                      // SCL falling edge.
        logic sda;                           // Current SDA level.
    } its_bus_ev_t;

    // Slave sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_AACK, ST_HOLD, ST_RX, ST_RACK,
        ST_TX, ST_TACK, ST_WSTOP
    } its_state_t;

endpackage : its_pkg

// [rtl/its_sync.sv]
/*
 * Two-flop synchroniser with edge pulses for asynchronous pin inputs.
 * Assumes the input may change at any time relative to clk_i.
 */
`timescale 1ns/1ps
module its_sync (
    input wire logic clk_i,    // System clock.
    input wire logic rst_b_i,  // Synchronous reset, active low.
    input wire logic d_i,      // Asynchronous level.
    output logic q_o,          // Synchronised level.
    output logic rise_o,       // One-cycle pulse on a rising edge.
    output logic fall_o        // One-cycle pulse on a falling edge.
);

    // ************************************************************
    // Synchroniser chain.
    // ************************************************************
    logic s1;  // First stage, read only by the second.
    logic s2;  // Second stage, safe to use.
    logic s3;  // Delayed copy for edge detection.

    // Reset high: an idle line shows no false edge.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
        end
    end

    assign q_o = s2;
    assign rise_o = s2 & ~s3;
    assign fall_o = ~s2 & s3;

endmodule : its_sync

// [rtl/its_slave.sv]
/*
 * Two-wire bus slave: shared data register, clock hold and
 * a bus time-out from the sub-clock divided by 32.
 * Assumes an outside master, open-drain pins resolved outside
 * and a sub-clock far slower than the system clock.
 */
`timescale 1ns/1ps
// What this block does
// R1 - Capture direction bit into master read flag.
// R2 - Acknowledge when calling address matches own.
// R3 - Master sends STOP after missing acknowledge.
// R4 - Direction select bit picks transmit or receive.
// R5 - Bytes are 8 bits, MSB first.
// R6 - Receiver acknowledges on ninth clock from bit.
// R7 - No master acknowledge: release SDA, await STOP.
// R8 - Shared data register for both directions.
// R9 - Hold SCL low until data access.
// R10 - Time-out starts on match, clears on fall.
// R11 - Period exceeded before fall declares time-out.
// R12 - STOP ends time-out supervision.
// R13 - Overflow halts counter, clears enable, sets flag.
// R14 - Time-out requests the shared interrupt.
// R15 - Time-out resets state and control B.
// R16 - Time-out flag stays until software clears.
// R17 - Period is field plus one ticks of 32.
// R18 - Compare seven address bits, flag and interrupt.
// R19 - Acknowledge received status: 0 seen, 1 none.
// R20 - Sub-clock tick synchronised before counting.
module its_slave
    import its_pkg::*;
(
    input wire logic clk_i,                    // System clock, 200 MHz.
    input wire logic rst_b_i,                  // Sync reset, active low.
    input wire logic [its_pkg::AW-1:0] addr_i, // Register address.
    input wire logic [its_pkg::DW-1:0] wdata_i,// Register write data.
    input wire logic we_i,                     // Write strobe.
    input wire logic re_i,                     // Read strobe.
    output logic [its_pkg::DW-1:0] rdata_o,    // Read data, next cycle.
    output logic irq_o,                        // Interrupt request pulse.
    input wire logic sub_clk_i,                // Slow sub-clock.
    input wire logic scl_i,                    // SCL pin level.
    output logic scl_o,                        // SCL drive value.
    output logic scl_oe_o,                     // SCL pulled low when high.
    input wire logic sda_i,                    // SDA pin level.
    output logic sda_o,                        // SDA drive value.
    output logic sda_oe_o                      // SDA pulled low when high.
);
    import its_pkg::*;

    // ************************************************************
    // Pin synchronisers and bus events.
    // ************************************************************
    logic scl_q;           // Synchronised SCL.
    logic scl_r;           // SCL rise pulse.
    logic scl_f;           // SCL fall pulse.
    logic sda_q;           // Synchronised SDA.
    logic sda_r;           // SDA rise pulse.
    logic sda_f;           // SDA fall pulse.
    logic sub_r;           // Sub-clock rise pulse.
    its_bus_ev_t ev;       // Decoded bus events.

    its_sync u_scl (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(scl_i),
        .q_o(scl_q),
        .rise_o(scl_r),
        .fall_o(scl_f)
    );

    its_sync u_sda (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(sda_i),
        .q_o(sda_q),
        .rise_o(sda_r),
        .fall_o(sda_f)
    );

    // The sub-clock is synchronised like a pin.
    its_sync u_sub (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .d_i(sub_clk_i),
        .q_o(),
        .rise_o(sub_r), // [R20]
        .fall_o()
    );

    // SDA edge direction tells a start from a stop.
    // Edges arrive a cycle apart.
    always_comb begin
        ev.start = sda_f & scl_q;
        ev.stop = sda_r & scl_q;
        ev.scl_rise = scl_r;
        ev.scl_fall = scl_f;
        ev.sda = sda_q;
    end

    // ************************************************************
    // Registers.
    // ************************************************************
    logic [DW-1:0] data_reg;   // Shared serial data register.
    logic [DW-1:0] own_addr;   // Own address register, low 7 bits.
    logic [DW-1:0] ctl_a;      // First control register.
    logic tds;                 // Transmit direction select.
    logic ack_to_send;         // Acknowledge level to send.
    logic amf;                 // Address matched flag.
    logic mrf;                 // Master read flag.
    logic ack_received_status;                // Acknowledge received status.
    logic to_en;               // Time-out enable.
    logic to_flag;             // Time-out flag.
    logic [TOC_PER_W-1:0] to_per;  // Time-out period select.
    logic [DW-1:0] ctl_b;      // Assembled control B view.
    logic [DW-1:0] toc;        // Assembled time-out control view.

    // ************************************************************
    // Sequencer state.
    // ************************************************************
    its_state_t state;         // Sequencer state.
    logic [BIT_W-1:0] bitcnt;  // Bits clocked in the current byte.
    logic [DW-1:0] sh;         // Shift register.
    logic ev_match;            // Address matched, one cycle.
    logic ev_byte;             // Byte complete, one cycle.
    logic to_ovf;              // Time-out overflow, one cycle.
    logic wr_data;             // Software writes the data register.
    logic rd_data;             // Software reads the data register.
    logic release_tx;          // Leave hold as transmitter.
    logic release_rx;          // Leave hold as receiver.

    assign wr_data = we_i && (addr_i == OFS_DATA);
    assign rd_data = re_i && (addr_i == OFS_DATA);
    assign release_tx = (state == ST_HOLD) && tds && wr_data; // [R9]
    assign release_rx = (state == ST_HOLD) && !tds && rd_data; // [R9]

    assign ctl_b = {1'b0, amf, 1'b0, tds, ack_to_send, mrf, 1'b0, ack_received_status};
    assign toc = {to_en, to_flag, to_per};

    // Data register: a software write or a received byte.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            data_reg <= DATA_RST;
        end else if (ev_byte && !tds) begin
            data_reg <= sh;                                 // [R8]
        end else if (wr_data) begin
            data_reg <= wdata_i;                            // [R8]
        end
    end

    // Address and control A survive a time-out.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            own_addr <= ADDR_RST;
            ctl_a <= CTLA_RST;
        end else if (we_i) begin
            if (addr_i == OFS_ADDR) begin
                own_addr <= wdata_i;
            end
            if (addr_i == OFS_CTLA) begin
                ctl_a <= wdata_i;
            end
        end
    end

    // Control B software bits; a time-out resets them.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || to_ovf) begin                      // [R15]
            tds <= 1'b0;
            ack_to_send <= 1'b0;
        end else if (we_i && (addr_i == OFS_CTLB)) begin
            tds <= wdata_i[CTLB_TDS];                       // [R4]
            ack_to_send <= wdata_i[CTLB_ACK];               // [R6]
        end
    end

    // Time-out control; hardware wins over a software write.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            to_en <= TOC_RST[TOC_EN];
            to_flag <= TOC_RST[TOC_FLAG];
            to_per <= TOC_RST[TOC_PER_HI:0];
        end else begin
            if (we_i && (addr_i == OFS_TOC)) begin
                to_en <= wdata_i[TOC_EN];
                to_flag <= wdata_i[TOC_FLAG];               // [R16]
                to_per <= wdata_i[TOC_PER_HI:0];
            end
            if (to_ovf) begin
                to_en <= 1'b0;                              // [R13]
                to_flag <= 1'b1;                            // [R13]
            end
        end
    end

    // Read data stand one cycle after the strobe.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !re_i) begin
            rdata_o <= '0;
        end else begin
            unique case (addr_i)
                OFS_DATA: rdata_o <= data_reg;
                OFS_ADDR: rdata_o <= own_addr;
                OFS_CTLA: rdata_o <= ctl_a;
                OFS_CTLB: rdata_o <= ctl_b;
                OFS_TOC: rdata_o <= toc;
                default: rdata_o <= '0;
            endcase
        end
    end

    // ************************************************************
    // Slave sequencer.
    // ************************************************************
    // Sample on SCL rise, drive after SCL fall,
    // so SDA never moves while SCL is high.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || to_ovf || !ctl_a[CTLA_EN]) begin   // [R15]
            state <= ST_IDLE;
            bitcnt <= '0;
            sh <= '0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            ev_match <= 1'b0;
            ev_byte <= 1'b0;
            amf <= 1'b0;
            mrf <= 1'b0;
            ack_received_status <= ACK_RECEIVED_STATUS_RST;
        end else begin
            ev_match <= 1'b0;
            ev_byte <= 1'b0;
            if (ev.start) begin
                // Any start restarts decoding.
                state <= ST_ADDR;
                bitcnt <= '0;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
                amf <= 1'b0;
            end else if (ev.stop) begin
                state <= ST_IDLE;
                sda_oe_o <= 1'b0;
                scl_oe_o <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        sda_oe_o <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (ev.scl_rise) begin
                            sh <= {sh[DW-2:0], ev.sda};     // [R18]
                            bitcnt <= bitcnt + 1'b1;
                            if (bitcnt == BITS_ADR) begin
                                if (sh[DW-2:0] == own_addr[DW-2:0]) begin
                                    mrf <= ev.sda;          // [R1]
                                    amf <= 1'b1;            // [R18]
                                    ev_match <= 1'b1;       // [R18]
                                    state <= ST_AACK;
                                end else begin
                                    state <= ST_WSTOP;
                                end
                            end
                        end
                    end
                    ST_AACK: begin
                        // Fall one drives the ack,
                        // fall two ends it and holds.
                        if (ev.scl_fall) begin
                            if (!sda_oe_o) begin
                                sda_oe_o <= 1'b1;           // [R2]
                            end else begin
                                sda_oe_o <= 1'b0;
                                scl_oe_o <= 1'b1;           // [R9]
                                state <= ST_HOLD;
                            end
                        end
                    end
                    ST_HOLD: begin
                        if (release_tx) begin
                            sh <= wdata_i;                  // [R8]
                            sda_oe_o <= ~wdata_i[DW-1];     // [R5]
                            scl_oe_o <= 1'b0;
                            bitcnt <= '0;
                            state <= ST_TX;                 // [R4]
                        end else if (release_rx) begin
                            scl_oe_o <= 1'b0;
                            bitcnt <= '0;
                            state <= ST_RX;                 // [R4]
                        end
                    end
                    ST_RX: begin
                        if (ev.scl_rise) begin
                            sh <= {sh[DW-2:0], ev.sda};     // [R5]
                            bitcnt <= bitcnt + 1'b1;
                            if (bitcnt == BITS_ADR) begin
                                ev_byte <= 1'b1;            // [R8]
                                state <= ST_RACK;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (ev.scl_fall) begin
                            if (bitcnt == BITS_BYTE) begin
                                sda_oe_o <= ~ack_to_send;   // [R6]
                                bitcnt <= '0;
                            end else begin
                                sda_oe_o <= 1'b0;
                                scl_oe_o <= 1'b1;           // [R9]
                                state <= ST_HOLD;
                            end
                        end
                    end
                    ST_TX: begin
                        if (ev.scl_rise) begin
                            bitcnt <= bitcnt + 1'b1;
                        end else if (ev.scl_fall) begin
                            if (bitcnt == BITS_BYTE) begin
                                sda_oe_o <= 1'b0;
                                state <= ST_TACK;
                            end else begin
                                sh <= {sh[DW-2:0], 1'b0};   // [R5]
                                sda_oe_o <= ~sh[DW-2];      // [R5]
                            end
                        end
                    end
                    ST_TACK: begin
                        if (ev.scl_rise) begin
                            ack_received_status <= ev.sda;                 // [R19]
                            ev_byte <= 1'b1;
                        end else if (ev.scl_fall) begin
                            if (!ack_received_status) begin
                                scl_oe_o <= 1'b1;           // [R9]
                                state <= ST_HOLD;
                            end else begin
                                state <= ST_WSTOP;          // [R7]
                            end
                        end
                    end
                    ST_WSTOP: begin
                        // Bus released; a stop or a start
                        // frees us, and the master owes
                        // a stop after a missing ack.
                        sda_oe_o <= 1'b0;                   // [R7] [R3]
                        scl_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain: drive low, enables decide.
    always_ff @(posedge clk_i) begin
        sda_o <= 1'b0;
        scl_o <= 1'b0;
    end

    // ************************************************************
    // Time-out supervisor.
    // ************************************************************
    logic [DIV_W-1:0] div_cnt;     // Sub-clock divider.
    logic tick;                    // One tick per 32 sub-clock cycles.
    logic to_active;               // Supervision running.
    logic [TOC_PER_W-1:0] to_cnt;  // Ticks since the last SCL fall.

    assign tick = sub_r && (div_cnt == DIV_W'(SUB_DIV - 1)); // [R17]
    // The (field + 1)-th tick passes the
    // field value: that is the overflow.
    assign to_ovf = to_active && tick && !ev.scl_fall
        && (to_cnt == to_per);                              // [R11] [R17]

    // Free divider: the first tick may come a
    // period early, traded for one counter.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            div_cnt <= '0;
        end else if (sub_r) begin
            div_cnt <= div_cnt + 1'b1;                      // [R20]
        end
    end

    // Arms on a match, clears on each SCL fall.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            to_active <= 1'b0;
            to_cnt <= '0;
        end else if (to_ovf || ev.stop || !to_en) begin
            to_active <= 1'b0;                              // [R12] [R13]
            to_cnt <= '0;
        end else if (ev_match) begin
            to_active <= 1'b1;                              // [R10]
            to_cnt <= '0;
        end else if (ev.scl_fall) begin
            to_cnt <= '0;                                   // [R10]
        end else if (to_active && tick) begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // One interrupt for match, byte and time-out.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= ev_match || ev_byte || to_ovf;         // [R14] [R18]
        end
    end

endmodule : its_slave

// [tb/its_slave_assertions.sv]
/* Port checker of its_slave, bound to it at the foot.
 * Assumes one clock domain and the open-drain pins resolved outside. */
`timescale 1ns/1ps
module its_chk import its_pkg::*; (
    input wire logic clk_i, rst_b_i, we_i, re_i, irq_o, sub_clk_i,
    input wire logic scl_i, scl_o, scl_oe_o, sda_i, sda_o, sda_oe_o,
    input wire logic [its_pkg::AW-1:0] addr_i,
    input wire logic [its_pkg::DW-1:0] wdata_i, rdata_o);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // A data register access frees a hold.
    wire logic dacc = (we_i | re_i) && addr_i == OFS_DATA;
    rd_idle_a: assert property (!$past(re_i) |-> rdata_o == 8'h00)
        else $error("read data outside slot");
    rsvd_bit_a: assert property ($past(re_i && addr_i == OFS_CTLB)
        |-> (rdata_o & 8'ha2) == 8'h00) else $error("reserved bits set");
    pin_zero_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("pin drive not low");
    irq_pulse_a: assert property (irq_o |=> !irq_o)
        else $error("long interrupt");
    sda_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i ||
        $fell(scl_oe_o)) else $error("data moved with clock high");
    hold_start_a: assert property ($rose(scl_oe_o) |-> !sda_oe_o)
        else $error("hold with data driven");
    hold_data_a: assert property (scl_oe_o && $past(scl_oe_o) |->
        $stable(sda_oe_o)) else $error("data moved in hold");
    hold_end_a: assert property ($fell(scl_oe_o) |-> $past(dacc) ||
        $past(dacc, 2) || irq_o || $past(irq_o)) else $error("early free");
    hold_c: cover property ($fell(scl_oe_o));
    irq_c: cover property (irq_o);
    ack_c: cover property ($rose(sda_oe_o));
endmodule : its_chk
bind its_slave its_chk u_chk (.clk_i, .rst_b_i, .we_i, .re_i, .irq_o,
    .sub_clk_i, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o, .sda_oe_o,
    .addr_i, .wdata_i, .rdata_o);

// [tb/its_master_model.sv]
/* Two-wire bus master model; an output of 1 releases the line.
 * Assumes pull-ups on both lines outside. */
`timescale 1ns/1ps
module its_bm (
    input wire logic clk_i,        // Pacing clock.
    input wire logic scl_i,        // Resolved clock line.
    input wire logic sda_i,        // Resolved data line.
    output logic scl_m_o = 1'b1,   // Clock pull, low drives.
    output logic sda_m_o = 1'b1);  // Data pull, low drives.
    // Quarter bit, far above the sync delay.
    task automatic q; repeat (20) @(posedge clk_i); endtask : q
    // Release SCL, honour a hold, bounded.
    task automatic up;
        scl_m_o <= 1'b1;
        for (int i = 0; i < 30000 && scl_i !== 1'b1; i++) @(posedge clk_i);
    endtask : up
    task automatic bx(input logic b, output logic r);
        sda_m_o <= b; q(); up(); q();
        r = sda_i; q(); scl_m_o <= 1'b0; q();
    endtask : bx
    task automatic send(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bx(v[i], r);
        bx(1'b1, ack);
    endtask : send
    task automatic recv(output logic [7:0] v, input logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) bx(1'b1, v[i]);
        bx(nak, r);
    endtask : recv
    task automatic start;
        sda_m_o <= 1'b1; up(); q(); sda_m_o <= 1'b0; q(); scl_m_o <= 1'b0; q();
    endtask : start
    task automatic stop;
        sda_m_o <= 1'b0; q(); up(); q(); sda_m_o <= 1'b1; q();
    endtask : stop
endmodule : its_bm

// [tb/tb_its_slave.sv]
/* Bench of its_slave: register tasks and a bus master.
 * Assumes the checker binds itself. */
`timescale 1ns/1ps
module tb_its_slave;
    import its_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, we_i = 1'b0, re_i = 1'b0;
    logic sub_clk_i = 1'b0, irq_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
    logic scl_m, sda_m, ack;
    logic [AW-1:0] addr_i = 3'h0;
    logic [DW-1:0] wdata_i = 8'h00, rdata_o, d;
    int mismatches = 0, n_tests = 0, cyc = 0, t;
    // Pulled-up lines, low if any side pulls.
    wire logic scl = scl_m & (scl_o | ~scl_oe_o);
    wire logic sda = sda_m & (sda_o | ~sda_oe_o);
    its_slave u_its_slave (.clk_i, .rst_b_i, .addr_i, .wdata_i, .we_i,
        .re_i, .rdata_o, .irq_o, .sub_clk_i, .scl_i(scl), .scl_o,
        .scl_oe_o, .sda_i(sda), .sda_o, .sda_oe_o);
    its_bm u_its_bm (.clk_i, .scl_i(scl), .sda_i(sda), .scl_m_o(scl_m),
        .sda_m_o(sda_m));
    initial forever #2.5 clk_i = ~clk_i;
    initial forever #50 sub_clk_i = ~sub_clk_i; // Sub-clock, 20 cycles.
    task automatic chk(input string n, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [AW-1:0] a, input logic [7:0] v);
        @(posedge clk_i); we_i <= 1'b1; addr_i <= a; wdata_i <= v;
        @(posedge clk_i); we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a, input logic [7:0] e, string n);
        @(posedge clk_i); re_i <= 1'b1; addr_i <= a;
        @(posedge clk_i); re_i <= 1'b0;
        @(negedge clk_i); chk(n, e, rdata_o);
    endtask : rd
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Watchdog: the run needs under half of this.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin mismatches++; summarize(); end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd(OFS_CTLB, 8'h01, "ctlb");
        rd(OFS_TOC, 8'h00, "toc");
        wr(OFS_TOC, 8'hbf);
        rd(OFS_TOC, 8'hbf, "toc_rw");
        wr(OFS_TOC, 8'h00);
        rd(3'h7, 8'h00, "gap");
        $display("regs done");
        wr(OFS_ADDR, 8'h2a);
        wr(OFS_CTLA, 8'h01);
        u_its_bm.start();
        u_its_bm.send(8'h54, ack);
        chk("a_ack", 8'h00, {7'h0, ack});
        chk("hold", 8'h01, {7'h0, scl_oe_o});
        rd(OFS_CTLB, 8'h41, "w_flag");
        wr(OFS_CTLB, 8'h00);
        rd(OFS_DATA, 8'h00, "dummy");
        u_its_bm.send(8'hc3, ack);
        chk("rx_ack", 8'h00, {7'h0, ack});
        rd(OFS_DATA, 8'hc3, "rx");
        u_its_bm.stop();
        $display("write done");
        u_its_bm.start();
        u_its_bm.send(8'h55, ack);
        rd(OFS_CTLB, 8'h45, "r_flag");
        wr(OFS_CTLB, 8'h10);
        wr(OFS_DATA, 8'h96);
        u_its_bm.recv(d, 1'b0);
        chk("tx1", 8'h96, d);
        rd(OFS_CTLB, 8'h54, "ack_in");
        wr(OFS_DATA, 8'h0f);
        u_its_bm.recv(d, 1'b1);
        chk("tx2", 8'h0f, d);
        rd(OFS_CTLB, 8'h55, "nak_in");
        chk("sda_free", 8'h00, {7'h0, sda_oe_o});
        u_its_bm.stop();
        u_its_bm.start();
        u_its_bm.send(8'h22, ack);
        chk("no_match", 8'h01, {7'h0, ack});
        u_its_bm.stop();
        $display("read done");
        wr(OFS_TOC, 8'h81);
        u_its_bm.start();
        u_its_bm.send(8'h54, ack);
        t = cyc;
        for (int i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge clk_i);
        chk("to_time", 8'h01, {7'h0, (cyc - t) inside
            {[SUB_DIV * 20 - 60 : 2 * SUB_DIV * 20 + 20]}});
        rd(OFS_TOC, 8'h41, "to_ctl");
        rd(OFS_CTLB, 8'h01, "to_ctlb");
        rd(OFS_ADDR, 8'h2a, "to_adr");
        chk("to_free", 8'h00, {7'h0, scl_oe_o});
        wr(OFS_TOC, 8'h01);
        rd(OFS_TOC, 8'h01, "to_clr");
        u_its_bm.stop();
        $display("timeout done");
        summarize();
    end
endmodule : tb_its_slave
